// ### logic/swcp_regs.vh
// command codes, field counts and framing characters of the setting write parser
`ifndef SWCP_REGS_VH
`define SWCP_REGS_VH
`define SWCP_CH_W 8'h57
`define SWCP_CH_CR 8'h0D
`define SWCP_CH_LF 8'h0A
`define SWCP_CH_0 8'h30
`define SWCP_CH_9 8'h39
`define SWCP_CH_A 8'h41
`define SWCP_CH_SP 8'h20
// code identifiers
`define SWCP_ID_NONE 3'h0
`define SWCP_ID_33 3'h1
`define SWCP_ID_40 3'h2
`define SWCP_ID_41 3'h3
`define SWCP_ID_44 3'h4
`define SWCP_ID_50 3'h5
`define SWCP_ID_A 3'h6
// digit field counts per command
`define SWCP_N_33 3'h5
`define SWCP_N_40 3'h5
`define SWCP_N_41 3'h3
`define SWCP_N_44 3'h4
`define SWCP_N_50 3'h5
`define SWCP_N_A 3'h5
`define SWCP_MAX_FIELDS 5
`endif

// ### logic/swcp_field_mem.v
// small field staging memory: digits of the frame in flight, registered read
module swcp_field_mem #(
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [3:0] wdata,
	input wire [AW-1:0] raddr,
	output reg [3:0] rdata
);
	reg [3:0] mem [0:DEPTH-1];

	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ### logic/swcp_parser.v
// setting write command parser: byte stream in, committed setting fields out
// Notes on behaviour
// - while soft lock holds, every setting write is refused and stored values stay
// - code 40: sequence mode, near-zero check, weight check, feed adjust, gate control
// - code 50: preset tare, gross/net source, discharge mode, tare key, gross/net key
// - code 33: second digital filter option and motion detection mode together
// - one command groups accumulation, one-touch tare, range, display, extended tare
// - tare-options command has code A0, five digits in grouped order, then CR LF
`include "swcp_regs.vh"
module swcp_parser (
	input wire clk,
	input wire nrst,
	input wire [7:0] rx_data,
	input wire rx_valid,
	input wire soft_lock,
	output reg [19:0] seq_opts_q,
	output reg [7:0] filt_md_q,
	output reg [11:0] judge_count_q,
	output reg [15:0] key_ss_q,
	output reg [19:0] tare_gn_q,
	output reg [19:0] tare_opts_q,
	output reg cmd_ok_q,
	output reg cmd_err_q,
	output reg cmd_locked_q
);
	// ************************************************
	// frame states
	// ************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_C1 = 3'h1;
	localparam ST_C2 = 3'h2;
	localparam ST_DIG = 3'h3;
	localparam ST_CR = 3'h4;
	localparam ST_LF = 3'h5;
	localparam ST_SKIP = 3'h6;
	localparam ST_COPY = 3'h7;

	reg [2:0] st_q, st_d;
	reg [7:0] c1_q, c1_d;
	reg [2:0] id_q, id_d;
	reg [2:0] cnt_q, cnt_d;
	reg [2:0] rd_q;
	reg wr_pend_q;
	reg [19:0] acc_q;
	reg we;
	reg bad;
	wire [3:0] rdata;

	function is_digit;
		input [7:0] c;
		begin
			is_digit = (c >= `SWCP_CH_0) && (c <= `SWCP_CH_9);
		end
	endfunction

	// ************************************************
	// code lookup
	// ************************************************
	function [2:0] code_id;
		input [7:0] a;
		input [7:0] b;
		begin
			code_id = `SWCP_ID_NONE;
			if (a == 8'h33 && b == 8'h33) code_id = `SWCP_ID_33;
			if (a == 8'h34 && b == 8'h30) code_id = `SWCP_ID_40;
			if (a == 8'h34 && b == 8'h31) code_id = `SWCP_ID_41;
			if (a == 8'h34 && b == 8'h34) code_id = `SWCP_ID_44;
			if (a == 8'h35 && b == 8'h30) code_id = `SWCP_ID_50;
			if (a == `SWCP_CH_A && b == `SWCP_CH_0) code_id = `SWCP_ID_A;
		end
	endfunction

	function [2:0] n_fields;
		input [2:0] id;
		begin
			case (id)
				`SWCP_ID_33: n_fields = `SWCP_N_33;
				`SWCP_ID_40: n_fields = `SWCP_N_40;
				`SWCP_ID_41: n_fields = `SWCP_N_41;
				`SWCP_ID_44: n_fields = `SWCP_N_44;
				`SWCP_ID_50: n_fields = `SWCP_N_50;
				`SWCP_ID_A: n_fields = `SWCP_N_A;
				default: n_fields = 3'h0;
			endcase
		end
	endfunction

	swcp_field_mem #(.DEPTH(8), .AW(3)) u_mem (
		.clk(clk),
		.we(we),
		.waddr(cnt_q),
		.wdata(rx_data[3:0]),
		.raddr(rd_q),
		.rdata(rdata)
	);

	// ************************************************
	// framing
	// ************************************************
	always @* begin
		st_d = st_q;
		c1_d = c1_q;
		id_d = id_q;
		cnt_d = cnt_q;
		we = 1'b0;
		bad = 1'b0;
		if (rx_valid) begin
			case (st_q)
				ST_IDLE: begin
					if (rx_data == `SWCP_CH_W) st_d = ST_C1;
				end
				ST_C1: begin
					c1_d = rx_data;
					cnt_d = 3'h0;
					// tare options are the only code led by a letter
					if (is_digit(rx_data) || rx_data == `SWCP_CH_A) begin
						st_d = ST_C2;
					end else begin
						st_d = ST_SKIP;
					end
				end
				ST_C2: begin
					// an unknown code drops the rest of the line
					id_d = code_id(c1_q, rx_data);
					st_d = (code_id(c1_q, rx_data) == `SWCP_ID_NONE) ? ST_SKIP : ST_DIG;
				end
				ST_DIG: begin
					if (is_digit(rx_data) && cnt_q < n_fields(id_q)) begin
						we = 1'b1;
						cnt_d = cnt_q + 3'h1;
						if (cnt_q + 3'h1 == n_fields(id_q)) st_d = ST_CR;
					end else begin
						st_d = ST_SKIP;
					end
				end
				ST_CR: st_d = (rx_data == `SWCP_CH_CR) ? ST_LF : ST_SKIP;
				ST_LF: st_d = (rx_data == `SWCP_CH_LF) ? ST_COPY : ST_SKIP;
				ST_SKIP: begin
					// resynchronise on the next line end
					if (rx_data == `SWCP_CH_LF) st_d = ST_IDLE;
				end
				// commit in progress: stray bytes are dropped, not decoded
				ST_COPY: st_d = ST_COPY;
				default: st_d = ST_IDLE;
			endcase
			// a line end that breaks a frame already resynchronises, so the
			// next frame is not swallowed while waiting for another one
			bad = (st_q != ST_SKIP) && (st_d == ST_SKIP);
			if (bad && rx_data == `SWCP_CH_LF) st_d = ST_IDLE;
		end
		if (st_q == ST_COPY && rd_q == 3'h7) st_d = ST_IDLE;
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
			c1_q <= 8'h00;
			id_q <= 3'h0;
			cnt_q <= 3'h0;
		end else begin
			st_q <= st_d;
			c1_q <= c1_d;
			id_q <= (st_q == ST_IDLE) ? `SWCP_ID_NONE : id_d;
			cnt_q <= cnt_d;
		end
	end

	// ************************************************
	// commit: read digits back one per cycle, then load the target
	// ************************************************
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_q <= 3'h0;
			wr_pend_q <= 1'b0;
			acc_q <= 20'h00000;
			seq_opts_q <= 20'h00000;
			filt_md_q <= 8'h00;
			judge_count_q <= 12'h000;
			key_ss_q <= 16'h0000;
			tare_gn_q <= 20'h00000;
			tare_opts_q <= 20'h00000;
			cmd_ok_q <= 1'b0;
			cmd_err_q <= 1'b0;
			cmd_locked_q <= 1'b0;
		end else begin
			cmd_ok_q <= 1'b0;
			cmd_err_q <= bad;
			cmd_locked_q <= 1'b0;
			wr_pend_q <= 1'b0;
			if (st_q != ST_COPY) begin
				rd_q <= 3'h0;
				acc_q <= 20'h00000;
			end else if (rd_q != 3'h7) begin
				rd_q <= rd_q + 3'h1;
				wr_pend_q <= 1'b1;
				if (rd_q + 3'h1 == {1'b0, n_fields(id_q)} + 3'h1) rd_q <= 3'h7;
			end
			// registered read lags the address by one cycle
			if (wr_pend_q && rd_q != 3'h0 && rd_q - 3'h1 < n_fields(id_q)) begin
				acc_q <= {acc_q[15:0], rdata};
			end
			if (st_q == ST_COPY && rd_q == 3'h7) begin
				if (soft_lock) begin
					cmd_locked_q <= 1'b1;
				end else begin
					cmd_ok_q <= 1'b1;
					case (id_q)
						`SWCP_ID_40: seq_opts_q <= acc_q;
						`SWCP_ID_50: tare_gn_q <= acc_q;
						`SWCP_ID_33: filt_md_q <= acc_q[7:0];
						`SWCP_ID_41: judge_count_q <= acc_q[11:0];
						`SWCP_ID_44: key_ss_q <= acc_q[15:0];
						`SWCP_ID_A: tare_opts_q <= acc_q;
						default: cmd_ok_q <= 1'b0;
					endcase
				end
			end
		end
	end
endmodule

// ### sim/swcp_properties.sv
// concurrent checks on the setting write parser ports
module swcp_properties (
	input logic clk,
	input logic nrst,
	input logic [7:0] rx_data,
	input logic rx_valid,
	input logic soft_lock,
	input logic [19:0] seq_opts_q,
	input logic [7:0] filt_md_q,
	input logic [11:0] judge_count_q,
	input logic [15:0] key_ss_q,
	input logic [19:0] tare_gn_q,
	input logic [19:0] tare_opts_q,
	input logic cmd_ok_q,
	input logic cmd_err_q,
	input logic cmd_locked_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [95:0] regs_all;
	logic lf_in;
	assign regs_all = {seq_opts_q, filt_md_q, judge_count_q, key_ss_q, tare_gn_q, tare_opts_q};
	assign lf_in = rx_valid && rx_data == 8'h0A;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_drop(x);
		##1 !x;
	endsequence
	a_ok_one_shot: assert property (cmd_ok_q |-> s_drop(cmd_ok_q))
		else $error("ok pulse longer than one cycle");
	a_lock_one_shot: assert property (cmd_locked_q |-> s_drop(cmd_locked_q))
		else $error("locked pulse longer than one cycle");
	a_lock_no_store: assert property (cmd_locked_q |-> $stable(regs_all) ##1 $stable(regs_all))
		else $error("settings changed on a locked frame");
	a_lock_needs_lock: assert property (cmd_locked_q |-> soft_lock || $past(soft_lock))
		else $error("locked pulse without soft lock");
	a_err_no_store: assert property (cmd_err_q |-> $stable(regs_all))
		else $error("settings changed on a broken frame");
	a_store_needs_ok: assert property (!$stable(regs_all) |-> cmd_ok_q)
		else $error("settings changed without ok pulse");
	a_ok_excl: assert property (cmd_ok_q |-> !cmd_locked_q && !cmd_err_q)
		else $error("ok pulse together with err or locked");
	a_err_after_byte: assert property (cmd_err_q |-> $past(rx_valid))
		else $error("err pulse not one cycle after a byte");
	a_ok_after_lf: assert property (cmd_ok_q |-> $past(lf_in, 5) || $past(lf_in, 6)
		|| $past(lf_in, 7) || $past(lf_in, 8))
		else $error("ok pulse not tied to a frame end");
endmodule
bind swcp_parser swcp_properties chk_i (.clk, .nrst, .rx_data, .rx_valid, .soft_lock,
	.seq_opts_q, .filt_md_q, .judge_count_q, .key_ss_q, .tare_gn_q, .tare_opts_q,
	.cmd_ok_q, .cmd_err_q, .cmd_locked_q);

// ### sim/swcp_host.sv
// host side model: sends setting write frames byte by byte
module swcp_host (
	input logic clk,
	output logic [7:0] rx_data,
	output logic rx_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
	end
	task automatic put(logic [7:0] b);
		@(posedge clk);
		rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_data <= ~b; // idle line must not look like a held byte
		rx_valid <= 1'b0;
	endtask
	// never issues output data writes, so no channel select wait arises
	task automatic send(string s);
		foreach (s[i]) put(s[i]);
		put(8'h0D);
		put(8'h0A);
	endtask
endmodule

// ### sim/tb_top.sv
// self-checking bench for the setting write parser
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic soft_lock = 1'b0;
	logic [7:0] rx_data;
	logic rx_valid;
	logic [19:0] seq_opts_q, tare_gn_q, tare_opts_q;
	logic [7:0] filt_md_q;
	logic [11:0] judge_count_q;
	logic [15:0] key_ss_q;
	logic cmd_ok_q, cmd_err_q, cmd_locked_q;
	int failures = 0;
	int samples_checked = 0;
	int ok_n = 0;
	int err_n = 0;
	int lock_n = 0;
	swcp_host host (.clk, .rx_data, .rx_valid);
	swcp_parser DUT (.clk, .nrst, .rx_data, .rx_valid, .soft_lock, .seq_opts_q, .filt_md_q,
		.judge_count_q, .key_ss_q, .tare_gn_q, .tare_opts_q, .cmd_ok_q, .cmd_err_q,
		.cmd_locked_q);
	initial begin
		forever #4 clk = ~clk;
	end
	// pulse counters; a test compares them before and after its frame
	always @(posedge clk) begin
		if (cmd_ok_q === 1'b1) ok_n <= ok_n + 1;
		if (cmd_err_q === 1'b1) err_n <= err_n + 1;
		if (cmd_locked_q === 1'b1) lock_n <= lock_n + 1;
	end
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(logic [19:0] got, logic [19:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// outcome code: 4 ok, 2 broken, 1 locked; pulses of another kind show as extra bits
	task automatic go(string s, logic lk, int e);
		int n;
		int ok0;
		int err0;
		int lock0;
		logic [2:0] ev;
		ok0 = ok_n;
		err0 = err_n;
		lock0 = lock_n;
		ev = 3'h0;
		soft_lock <= lk;
		host.send(s);
		for (n = 0; n < 20 && ev == 3'h0; n++) begin
			@(posedge clk);
			ev = {ok_n != ok0, err_n != err0, lock_n != lock0};
		end
		repeat (8) @(posedge clk);
		ev = {ok_n != ok0, err_n != err0, lock_n != lock0};
		chk(20'(ev), 20'(e));
		$display("test %s done", s);
		if (ev == 3'h0) tally_and_finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		go("W4012345", 1'b0, 4);
		chk(seq_opts_q, 20'h12345);
		go("W5067890", 1'b0, 4);
		chk(tare_gn_q, 20'h67890);
		go("W3301234", 1'b0, 4);
		chk(20'(filt_md_q), 20'h00034);
		go("W41907", 1'b0, 4);
		chk(20'(judge_count_q), 20'h00907);
		go("W449876", 1'b0, 4);
		chk(20'(key_ss_q), 20'h09876);
		go("WA013579", 1'b0, 4);
		chk(tare_opts_q, 20'h13579);
		go("W4054321", 1'b1, 1);
		chk(seq_opts_q, 20'h12345);
		go("W4012X45", 1'b0, 2);
		go("W401234", 1'b0, 2);
		go("W99123", 1'b0, 2);
		go("W4167", 1'b0, 2);
		chk(seq_opts_q, 20'h12345);
		chk(20'(judge_count_q), 20'h00907);
		go("WA 13579", 1'b0, 2);
		chk(tare_opts_q, 20'h13579);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk(seq_opts_q, 20'h00000);
		chk(20'(judge_count_q), 20'h00000);
		go("W41123", 1'b0, 4);
		chk(20'(judge_count_q), 20'h00123);
		tally_and_finish;
	end
endmodule
